/* File: sfr_host.sv */
// Purpose: host controller end: APB registers drive serial command frames
// Assumes: software follows the retry and diagnosis procedures
// Notes: link clock made here by a divider of CLK_SYS_IN
`timescale 1ns/1ps
module sfr_host #(
  parameter int HALF_CYC = sfr_pkg::SCLK_HALF_CYC
) (
  // system
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // apb slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // serial link
  sfr_link_if.host LINK
);
  import sfr_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL} sfr_state_type;

  sfr_state_type state_q;
  logic [7:0] cnt_q;
  logic [4:0] bit_q;
  logic [15:0] tx_q;
  logic [15:0] rx_q;
  logic [CMD_W-1:0] cmd_q;
  logic [2:0] ctrl_q;
  logic [4:0] stat_q;
  logic retried_q;
  logic cs_b_q;
  logic sclk_q;
  logic mosi_q;
  logic mode_q;
  logic miso_m_q;
  logic miso_s_q;
  logic setup;
  logic wr;
  logic start;
  logic half_done;
  logic [4:0] last_bit;
  logic [CMD_W-1:0] status_b;
  logic any_one;
  logic retry;

  assign setup = PSEL_IN && !PENABLE_IN;
  assign wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign start = wr && (PADDR_IN == REG_CMD_OFF) && (state_q == H_IDLE);
  assign half_done = (cnt_q == 8'(HALF_CYC - 1));
  assign last_bit = ctrl_q[CTRL_DOUBLE_BIT] ? 5'h0F : 5'h07;
  assign status_b = ctrl_q[CTRL_DOUBLE_BIT] ? rx_q[15:8] : rx_q[7:0];
  assign any_one = |status_b;
  assign retry = any_one && ctrl_q[CTRL_AUTO_RETRY_BIT] && !retried_q;

  // ---------------------------------------------------------------
  // apb register access
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      PRDATA_OUT <= '0;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
    else
    begin
      PREADY_OUT <= 1'b1;
      if (setup)
      begin
        PSLVERR_OUT <= !(PADDR_IN inside {REG_CMD_OFF, REG_CTRL_OFF, REG_STAT_OFF, REG_RX_OFF});
        unique case (PADDR_IN)
          REG_CMD_OFF: PRDATA_OUT <= {24'h000000, cmd_q};
          REG_CTRL_OFF: PRDATA_OUT <= {29'h00000000, ctrl_q};
          REG_STAT_OFF: PRDATA_OUT <= {27'h0000000, stat_q[4:1], (state_q != H_IDLE)};
          REG_RX_OFF: PRDATA_OUT <= {16'h0000, rx_q};
          default: PRDATA_OUT <= '0;
        endcase
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      cmd_q <= '0;
      ctrl_q <= CTRL_RESET;
    end
    else
    begin
      if (start)
        cmd_q <= PWDATA_IN[CMD_W-1:0];
      if (wr && PADDR_IN == REG_CTRL_OFF)
        ctrl_q <= PWDATA_IN[2:0];
    end
  end

  // ---------------------------------------------------------------
  // mode pin: held high until a command has gone out
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      mode_q <= 1'b1;
    else
      mode_q <= ctrl_q[CTRL_MODE_HIGH_BIT] || !stat_q[STAT_SENT_BIT];
  end

  // ---------------------------------------------------------------
  // serial input synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      miso_m_q <= 1'b1;
      miso_s_q <= 1'b1;
    end
    else
    begin
      miso_m_q <= LINK.miso;
      miso_s_q <= miso_m_q;
    end
  end

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      state_q <= H_IDLE;
      cnt_q <= '0;
      bit_q <= '0;
      tx_q <= '0;
      rx_q <= '0;
      stat_q <= '0;
      retried_q <= 1'b0;
      cs_b_q <= 1'b1;
      sclk_q <= 1'b0;
      mosi_q <= 1'b0;
    end
    else
    begin
      cnt_q <= (state_q == H_IDLE || half_done) ? 8'h00 : cnt_q + 8'h01;
      unique case (state_q)
        H_IDLE:
          if (start)
          begin
            tx_q <= {PWDATA_IN[CMD_W-1:0], PWDATA_IN[CMD_W-1:0]};
            mosi_q <= PWDATA_IN[CMD_W-1];
            cs_b_q <= 1'b0;
            bit_q <= '0;
            retried_q <= 1'b0;
            state_q <= H_LEAD;
          end
        H_LEAD, H_LOW:
          if (half_done)
          begin
            sclk_q <= 1'b1;
            rx_q <= {rx_q[14:0], miso_s_q};
            state_q <= H_HIGH;
          end
        H_HIGH:
          if (half_done)
          begin
            sclk_q <= 1'b0;
            tx_q <= {tx_q[14:0], 1'b0};
            mosi_q <= tx_q[14];
            bit_q <= bit_q + 5'h01;
            state_q <= (bit_q == last_bit) ? H_TAIL : H_LOW;
          end
        H_TAIL:
          if (half_done)
          begin
            stat_q[STAT_SENT_BIT] <= 1'b1;
            stat_q[STAT_ANY_ONE_BIT] <= any_one;
            stat_q[STAT_ALL_ONES_BIT] <= &status_b;
            stat_q[STAT_ECHO_BAD_BIT] <= ctrl_q[CTRL_DOUBLE_BIT] && (rx_q[7:0] != cmd_q);
            if (cs_b_q)
            begin
              // resend of the same command confirms set bits
              if (retry)
              begin
                tx_q <= {cmd_q, cmd_q};
                mosi_q <= cmd_q[CMD_W-1];
                cs_b_q <= 1'b0;
                bit_q <= '0;
                retried_q <= 1'b1;
                state_q <= H_LEAD;
              end
              else
                state_q <= H_IDLE;
            end
            else
              cs_b_q <= 1'b1;
          end
        default: state_q <= H_IDLE;
      endcase
    end
  end

  assign LINK.cs_b = cs_b_q;
  assign LINK.sclk = sclk_q;
  assign LINK.mosi = mosi_q;
  assign LINK.mode_sel = mode_q;

endmodule

/* File: sfr_pkg.sv */
// Purpose: shared constants of the switch fault report link
// Assumes: 40 MHz system clock on both ends
// Notes: host register map and timing counts live here
package sfr_pkg;

  // channel layout
  localparam int NCH = 8;
  localparam int NHP = 6;
  localparam int CMD_W = 8;
  localparam int OLON_LO_BIT = 6;
  localparam int OLON_HI_BIT = 7;
  localparam int OLON_LO_LAST = 2;

  // host register offsets (byte addresses)
  localparam logic [7:0] REG_CMD_OFF = 8'h00;
  localparam logic [7:0] REG_CTRL_OFF = 8'h04;
  localparam logic [7:0] REG_STAT_OFF = 8'h08;
  localparam logic [7:0] REG_RX_OFF = 8'h0C;

  // control fields
  localparam int CTRL_MODE_HIGH_BIT = 0;
  localparam int CTRL_DOUBLE_BIT = 1;
  localparam int CTRL_AUTO_RETRY_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h1;

  // status fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ANY_ONE_BIT = 1;
  localparam int STAT_ALL_ONES_BIT = 2;
  localparam int STAT_ECHO_BAD_BIT = 3;
  localparam int STAT_SENT_BIT = 4;

  // timing
  localparam int SYS_PERIOD_NS = 25;
  localparam int SCLK_PERIOD_NS = 800;
  localparam int SCLK_HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);

endpackage

/* File: sfr_link_if.sv */
// Purpose: serial link between host controller and switch device
// Assumes: serial output is pulled up when released
// Notes: resolves the tri-state serial output from its enable
`timescale 1ns/1ps
interface sfr_link_if;
  logic cs_b;
  logic sclk;
  logic mosi;
  logic mode_sel;
  logic miso_out;
  logic miso_oe_b;
  logic miso;

  // pull-up when the device releases the line
  assign miso = miso_oe_b ? 1'b1 : miso_out;

  modport dev (
    input cs_b,
    input sclk,
    input mosi,
    input mode_sel,
    output miso_out,
    output miso_oe_b
  );

  modport host (
    output cs_b,
    output sclk,
    output mosi,
    output mode_sel,
    input miso
  );
endinterface

/* File: sfr_device.sv */
// Purpose: switch device end: serial command, fault status, channel drive
// Assumes: all pins asynchronous to CLK_SYS_IN, sampled through two flops
// Notes: analog fault and overvoltage comparators arrive as pins
// Contract
// - overvoltage forces channels off, ignores inputs
// - leave overvoltage only below hysteresis level
// - no faults gives all-zero status byte
// - host resends command on any one
// - double command returns status then echo
// - echoed command equals bits sent
// - host checks mode line on all ones
// - off high-power channel senses open/ground only
// - on, detect disabled: fault means short
// - host disables on-detect then rereads
// - low bits: off open, on short
// - host restores state, sends command twice
// - host avoids reads during parallel switching
// - power-on reset clears command register
// - host writes command before mode low
// - reset independent of supply order
// - fault bits sticky until read
// - chip select freezes, then applies command
// - mode high stores command, tri-states output
`timescale 1ns/1ps
module sfr_device (
  // system
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // serial link
  sfr_link_if.dev LINK,
  // parallel control
  input wire logic [sfr_pkg::NHP-1:0] PAR_CHAN_IN,
  input wire logic [1:0] LOW_PWR_IN,
  // fault sensing
  input wire logic [sfr_pkg::NCH-1:0] OPEN_LOAD_IN,
  input wire logic [sfr_pkg::NCH-1:0] SHORT_IN,
  input wire logic SHORT_SHUTDOWN_IN,
  input wire logic OV_TRIP_IN,
  input wire logic OV_CLEAR_IN,
  // channel drive
  output logic [sfr_pkg::NCH-1:0] CHAN_ON_OUT,
  output logic OV_ACTIVE_OUT
);
  import sfr_pkg::*;

  localparam int SW = 4 + NHP + 2 + 2 * NCH + 3;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;
  logic cs_b_s;
  logic sclk_s;
  logic mosi_s;
  logic mode_s;
  logic [NHP-1:0] par_s;
  logic [1:0] low_s;
  logic [NCH-1:0] open_s;
  logic [NCH-1:0] short_s;
  logic shutdown_s;
  logic ov_trip_s;
  logic ov_clear_s;
  logic sclk_prev_q;
  logic cs_prev_q;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  logic [CMD_W-1:0] shift_q;
  logic [CMD_W-1:0] frozen_q;
  logic [CMD_W-1:0] cmd_q;
  logic [NCH-1:0] fault_q;
  logic [NCH-1:0] det;
  logic so_q;
  logic so_oe_b_q;
  logic ov_q;
  logic [NCH-1:0] chan_q;
  logic [NCH-1:0] chan_d;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      // chip select starts at its idle level: no false frame edge after reset
      sync1_q <= {1'b1, {(SW - 1){1'b0}}};
      sync2_q <= {1'b1, {(SW - 1){1'b0}}};
    end
    else
    begin
      sync1_q <= {LINK.cs_b, LINK.sclk, LINK.mosi, LINK.mode_sel, PAR_CHAN_IN, LOW_PWR_IN,
                  OPEN_LOAD_IN, SHORT_IN, SHORT_SHUTDOWN_IN, OV_TRIP_IN, OV_CLEAR_IN};
      sync2_q <= sync1_q;
    end
  end

  assign {cs_b_s, sclk_s, mosi_s, mode_s, par_s, low_s, open_s, short_s, shutdown_s, ov_trip_s,
          ov_clear_s} = sync2_q;

  // ---------------------------------------------------------------
  // link edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      sclk_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_s;
      cs_prev_q <= cs_b_s;
    end
  end

  assign sclk_rise = !cs_b_s && sclk_s && !sclk_prev_q;
  assign sclk_fall = !cs_b_s && !sclk_s && sclk_prev_q;
  assign cs_fall = cs_prev_q && !cs_b_s;
  assign cs_rise = !cs_prev_q && cs_b_s;

  // ---------------------------------------------------------------
  // serial shift path
  // ---------------------------------------------------------------
  // an 8-bit register passes a 16-bit frame through: status then echo
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
    begin
      shift_q <= '0;
      frozen_q <= '0;
      so_q <= 1'b0;
    end
    else if (cs_fall)
    begin
      shift_q <= fault_q;
      frozen_q <= fault_q;
      so_q <= fault_q[CMD_W-1];
    end
    else if (sclk_rise)
    begin
      shift_q <= {shift_q[CMD_W-2:0], mosi_s};
    end
    else if (sclk_fall)
    begin
      so_q <= shift_q[CMD_W-1];
    end
  end

  // output released outside frames and while mode is high
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      so_oe_b_q <= 1'b1;
    else
      so_oe_b_q <= cs_b_s || mode_s;
  end

  assign LINK.miso_out = so_q;
  assign LINK.miso_oe_b = so_oe_b_q;

  // ---------------------------------------------------------------
  // command register
  // ---------------------------------------------------------------
  // asynchronous reset clears it whatever the supply order
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      cmd_q <= '0;
    else if (cs_rise && !ov_q)
      cmd_q <= shift_q;
  end

  // ---------------------------------------------------------------
  // overvoltage latch
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      ov_q <= 1'b0;
    else if (ov_trip_s)
      ov_q <= 1'b1;
    else if (ov_clear_s)
      ov_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // fault classification and sticky register
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < NCH; i++)
    begin : g_det
      if (i < NHP)
      begin : g_hp
        logic olon;
        assign olon = (i <= OLON_LO_LAST) ? cmd_q[OLON_LO_BIT] : cmd_q[OLON_HI_BIT];
        assign det[i] = chan_q[i] ? (short_s[i] || (olon && open_s[i])) : open_s[i];
      end
      else
      begin : g_lp
        assign det[i] = chan_q[i] ? short_s[i] : open_s[i];
      end
    end
  endgenerate

  // new faults always win over the clear of a read
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      fault_q <= '0;
    else if (cs_rise && !mode_s)
      fault_q <= (fault_q & ~frozen_q) | det;
    else
      fault_q <= fault_q | det;
  end

  // ---------------------------------------------------------------
  // channel drive
  // ---------------------------------------------------------------
  always_comb
  begin
    chan_d = {low_s, (mode_s ? par_s : cmd_q[NHP-1:0])};
    if (ov_q || shutdown_s)
      chan_d = '0;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      chan_q <= '0;
    else
      chan_q <= chan_d;
  end

  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      OV_ACTIVE_OUT <= 1'b0;
    else
      OV_ACTIVE_OUT <= ov_q;
  end

  assign CHAN_ON_OUT = chan_q;

endmodule

/* File: sfr_checker.sv */
// Purpose: link timing checks between host and device ends
// Assumes: HALF_CYC equals the host instance parameter
// Notes: watches the shared serial interface only
`timescale 1ns/1ps
module sfr_checker #(
  parameter int HALF_CYC = 8
) (
  // system
  input wire logic CLK_SYS_IN,
  input wire logic RST_B_IN,
  // serial link
  input wire logic cs_b,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic mode_sel,
  input wire logic miso_out,
  input wire logic miso_oe_b
);
  int low_cnt_q;
  logic framed_q;
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!RST_B_IN);

  // ----------------------------------------
  // helper state
  // ----------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      low_cnt_q <= 0;
    else if (!cs_b)
      low_cnt_q <= low_cnt_q + 1;
    else
      low_cnt_q <= 0;
  end

  // set once the first frame has ended
  always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN)
  begin
    if (!RST_B_IN)
      framed_q <= 1'b0;
    else if (cs_b && low_cnt_q != 0)
      framed_q <= 1'b1;
  end

  // ----------------------------------------
  // properties
  // ----------------------------------------
  property p_miso_release;
    $rose(cs_b) |-> ##[1:6] miso_oe_b;
  endproperty
  a_miso_release: assert property (p_miso_release) else $error("serial output not released after frame");

  property p_miso_drive;
    $fell(cs_b) && !mode_sel |-> ##[2:6] !miso_oe_b;
  endproperty
  a_miso_drive: assert property (p_miso_drive) else $error("serial output not driven in frame");

  property p_mode_release;
    mode_sel [*8] |-> miso_oe_b;
  endproperty
  a_mode_release: assert property (p_mode_release) else $error("serial output driven with mode high");

  property p_sclk_idle;
    cs_b |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock active outside frame");

  property p_mosi_hold;
    sclk && !cs_b |-> $stable(mosi);
  endproperty
  a_mosi_hold: assert property (p_mosi_hold) else $error("command data moved while clock high");

  property p_miso_hold;
    sclk && $past(sclk) && !miso_oe_b |-> $stable(miso_out);
  endproperty
  a_miso_hold: assert property (p_miso_hold) else $error("status data moved while clock high");

  property p_frame_len;
    $rose(cs_b) |-> (low_cnt_q == 17 * HALF_CYC) || (low_cnt_q == 33 * HALF_CYC);
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length not 8 or 16 bits");

  property p_mode_order;
    $fell(mode_sel) |-> framed_q;
  endproperty
  a_mode_order: assert property (p_mode_order) else $error("mode lowered before first command");
endmodule

/* File: sfr_tb.sv */
// Purpose: self-checking bench joining host and device ends
// Assumes: 40 MHz clock, short serial divider
// Notes: software reaches the host over APB
`timescale 1ns/1ps
module sfr_tb;
  import sfr_pkg::*;
  localparam int HC = 8;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, short_sd, ov_trip, ov_clear, ov_active, serr;
  logic [7:0] paddr, open_load, short_in, chan_on;
  logic [31:0] pwdata, prdata, rdat;
  logic [5:0] par_chan;
  logic [1:0] low_pwr;
  int error_cnt, checked, cyc;
  logic [7:0] t_cmd [7] = '{8'h05, 8'h05, 8'h05, 8'h45, 8'h45, 8'h05, 8'h05};
  logic [7:0] t_open [7] = '{8'h8B, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00};
  logic [7:0] t_short [7] = '{8'h14, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [15:0] t_rx [7] = '{16'h8E05, 16'h8E05, 16'h0005, 16'h0045, 16'h0145, 16'h0105, 16'h0005};

  sfr_link_if u_sfr_link_if ();
  sfr_host #(.HALF_CYC(HC)) u_sfr_host (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LINK(u_sfr_link_if.host));
  sfr_device u_sfr_device (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .LINK(u_sfr_link_if.dev),
    .PAR_CHAN_IN(par_chan), .LOW_PWR_IN(low_pwr), .OPEN_LOAD_IN(open_load), .SHORT_IN(short_in),
    .SHORT_SHUTDOWN_IN(short_sd), .OV_TRIP_IN(ov_trip), .OV_CLEAR_IN(ov_clear), .CHAN_ON_OUT(chan_on),
    .OV_ACTIVE_OUT(ov_active));
  sfr_checker #(.HALF_CYC(HC)) u_sfr_checker (.CLK_SYS_IN(clk), .RST_B_IN(rst_b), .cs_b(u_sfr_link_if.cs_b),
    .sclk(u_sfr_link_if.sclk), .mosi(u_sfr_link_if.mosi), .mode_sel(u_sfr_link_if.mode_sel),
    .miso_out(u_sfr_link_if.miso_out), .miso_oe_b(u_sfr_link_if.miso_oe_b));

  always #12.5 clk = ~clk;

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // one apb transfer, result left in rdat and serr
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // send one command, wait for idle, leave received bits in rdat
  task automatic frame(input logic [7:0] cmd);
    apb(1'b1, REG_CMD_OFF, {24'h0, cmd});
    repeat (4) @(posedge clk);
    rdat = 32'h1;
    while (rdat[STAT_BUSY_BIT] === 1'b1)
      apb(1'b0, REG_STAT_OFF, 32'h0);
    apb(1'b0, REG_RX_OFF, 32'h0);
  endtask

  task automatic settle();
    repeat (12) @(posedge clk);
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 25000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {clk, rst_b, psel, penable, pwrite, short_sd, ov_trip, ov_clear} = '0;
    {paddr, pwdata, open_load, short_in, par_chan, low_pwr} = '0;
    error_cnt = 0;
    checked = 0;
    cyc = 0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("chan at power-up", chan_on, 32'h0);
    apb(1'b0, REG_CTRL_OFF, 32'h0);
    chk("ctrl reset", rdat, {29'h0, CTRL_RESET});
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", serr, 32'h1);
    chk("unmapped data", rdat, 32'h0);
    // command stored while serial control is off
    apb(1'b1, REG_CTRL_OFF, 32'h0);
    frame(8'h05);
    chk("rx mode high", rdat, 32'h00FF);
    apb(1'b0, REG_STAT_OFF, 32'h0);
    chk("status all ones", rdat, 32'h16);
    settle();
    chk("chan after init", chan_on, 32'h05);
    apb(1'b1, REG_CTRL_OFF, 32'h2);
    frame(8'h05);
    chk("rx double", rdat, 32'h0005);
    apb(1'b0, REG_STAT_OFF, 32'h0);
    chk("status flags", rdat[3:1], 32'h0);
    for (int i = 0; i < 7; i++)
    begin
      open_load <= t_open[i];
      short_in <= t_short[i];
      settle();
      frame(t_cmd[i]);
      chk("rx fault", rdat, {16'h0, t_rx[i]});
    end
    // fault gone before the resend: auto retry reads a clean status
    apb(1'b1, REG_CTRL_OFF, 32'h6);
    open_load <= 8'h02;
    settle();
    open_load <= 8'h00;
    settle();
    frame(8'h05);
    chk("rx after retry", rdat, 32'h0005);
    // overvoltage and short shutdown
    low_pwr <= 2'b11;
    ov_trip <= 1'b1;
    settle();
    chk("ov on", {ov_active, chan_on}, 32'h100);
    frame(8'h3F);
    ov_trip <= 1'b0;
    settle();
    chk("ov held", {ov_active, chan_on}, 32'h100);
    ov_clear <= 1'b1;
    settle();
    chk("ov left", {ov_active, chan_on}, 32'h0C5);
    ov_clear <= 1'b0;
    short_sd <= 1'b1;
    settle();
    chk("short shutdown", chan_on, 32'h0);
    short_sd <= 1'b0;
    settle();
    chk("short released", chan_on, 32'hC5);
    // parallel control, then stored command takes over
    apb(1'b1, REG_CTRL_OFF, 32'h1);
    par_chan <= 6'h2A;
    // no frame while parallel outputs are still switching
    settle();
    chk("parallel", chan_on, 32'hEA);
    // 8-bit frame shifts on top of the echo byte of the last frame
    frame(8'h11);
    chk("rx released", rdat, 32'h3FFF);
    chk("parallel kept", chan_on, 32'hEA);
    apb(1'b1, REG_CTRL_OFF, 32'h0);
    settle();
    chk("stored cmd", chan_on, 32'hD1);
    frame(8'h11);
    chk("rx single", rdat, 32'hFF00);
    // second power-on reset mid-run
    par_chan <= 6'h00;
    low_pwr <= 2'b00;
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    settle();
    chk("chan after reset", chan_on, 32'h0);
    give_verdict();
  end
endmodule
